// ### rtl/nco_guard_pkg.sv
// Shared constants and carrier types for the oscillator tuning and hold guardband registers.
package nco_guard_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int INC_W = 10;
	localparam int GB_W = 3;
	localparam logic [ADDR_W-1:0] OFS_INC_LOW = 10'h139;
	localparam logic [ADDR_W-1:0] OFS_INC_HIGH = 10'h13a;
	localparam logic [ADDR_W-1:0] OFS_HOLD_GB = 10'h13b;
	localparam logic [DATA_W-1:0] RST_INC_LOW = 8'h00;
	localparam logic [DATA_W-1:0] RST_INC_HIGH = 8'h00;
	localparam logic [DATA_W-1:0] RST_HOLD_GB = 8'h00;
	localparam int INC_LOW_LSB = 0;
	localparam int INC_HIGH_LSB = 0;
	localparam int INC_HIGH_W = 2;
	localparam int GB_LSB = 5;
	localparam int GB_RSV_W = 5;
	localparam int PHASE_MOD = 1024;
	localparam int GB_STEP_PS = 35;
	localparam int GB_MAX_PS = 245;
	localparam int GB_PS_W = 8;

	// Register write/read request from the serial control port.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	// All state of the register bank.
	typedef struct packed {
		logic [DATA_W-1:0] incLow;
		logic [INC_HIGH_W-1:0] incHigh;
		logic [GB_W-1:0] guard;
		logic [GB_RSV_W-1:0] guardRsv;
		logic [INC_W-1:0] incOut;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
	} bank_state_t;
endpackage

// ### rtl/nco_tuning_and_hold_guard_regs.sv
// Register bank for the second downconverter oscillator increment and the hold guardband.
// Overview of operation
// (RULE_01) Offset 0x139 bits 7..0 hold the low increment byte, read-write.
// (RULE_02) Offset 0x13a bits 1..0 hold increment bits 9..8; bits 7..2 unused.
// (RULE_03) Oscillator frequency is increment times sample rate divided by 1024.
// (RULE_04) Offset 0x13b bits 7..5 widen the hold window for the hold flag.
// (RULE_05) Each guardband code step adds 35 ps; code 111 adds 245 ps.
// (RULE_06) Guardband only affects flag raising, never capture timing or hold.
// (RULE_07) All three registers reset to 0x00.
// (RULE_08) Increment halves are presented to the oscillator together as one word.
`timescale 1ns/1ps
`default_nettype none
module nco_tuning_and_hold_guard_regs
	import nco_guard_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic nrst,
	// Register port from the serial control logic.
	input wire reg_req_t req,
	input wire logic xferStrobe,
	output logic [DATA_W-1:0] rdata,
	output logic rvalid,
	// Oscillator and hold flag logic.
	output logic [INC_W-1:0] phaseIncrement,
	output logic [GB_W-1:0] holdGuardCode,
	output logic [GB_PS_W-1:0] holdGuardPs
);
	// Elaboration checks: the fields must fit the byte and the increment word, and the scale, modulus and picosecond width must agree.
	if (INC_HIGH_W + DATA_W != INC_W) begin : g_bad_inc
		$error("increment width mismatch");
	end
	if (GB_STEP_PS * ((1 << GB_W) - 1) != GB_MAX_PS) begin : g_bad_scale
		$error("guardband scale mismatch");
	end
	if (PHASE_MOD != (1 << INC_W)) begin : g_bad_mod
		$error("phase modulus mismatch");
	end
	if (GB_LSB + GB_W != DATA_W || GB_RSV_W != GB_LSB) begin : g_bad_guard
		$error("guardband field layout mismatch");
	end
	if (GB_MAX_PS >= (1 << GB_PS_W)) begin : g_bad_ps
		$error("guardband picosecond width too small");
	end
	if (INC_HIGH_LSB + INC_HIGH_W > DATA_W || INC_LOW_LSB != 0) begin : g_bad_high
		$error("increment field layout mismatch");
	end

	bank_state_t st_r;
	bank_state_t st_nxt;

	function automatic logic hit(input reg_req_t r, input logic [ADDR_W-1:0] ofs);
		hit = r.addr == ofs;
	endfunction

	// Unused increment bits and unmapped offsets read as zero, so software never
	// sees leftovers of an earlier access on the read bus.
	function automatic logic [DATA_W-1:0] read_word(input bank_state_t s,
		input logic [ADDR_W-1:0] a);
		case (a)
			OFS_INC_LOW: begin
				read_word = s.incLow; // [RULE_01]
			end
			OFS_INC_HIGH: begin
				read_word = {{(DATA_W - INC_HIGH_W){1'b0}}, s.incHigh}; // [RULE_02]
			end
			OFS_HOLD_GB: begin
				read_word = {s.guard, s.guardRsv}; // [RULE_04]
			end
			default: begin
				read_word = 8'h00;
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.rvalid = req.rd;
		st_nxt.rdata = 8'h00;
		if (req.wr) begin
			if (hit(req, OFS_INC_LOW)) begin
				st_nxt.incLow = req.wdata; // [RULE_01]
			end
			if (hit(req, OFS_INC_HIGH)) begin
				st_nxt.incHigh = req.wdata[INC_HIGH_LSB +: INC_HIGH_W]; // [RULE_02]
			end
			if (hit(req, OFS_HOLD_GB)) begin
				st_nxt.guard = req.wdata[GB_LSB +: GB_W]; // [RULE_04]
				st_nxt.guardRsv = req.wdata[0 +: GB_RSV_W];
			end
		end
		if (req.rd) begin
			st_nxt.rdata = read_word(st_r, req.addr);
		end
		// Both halves move to the oscillator only on a transfer strobe, so the
		// increment never mixes a stale half with a fresh one.
		if (xferStrobe) begin
			st_nxt.incOut = {st_nxt.incHigh, st_nxt.incLow}; // [RULE_08] [RULE_03]
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r.incLow <= RST_INC_LOW; // [RULE_07]
			st_r.incHigh <= RST_INC_HIGH[INC_HIGH_W-1:0];
			st_r.guard <= RST_HOLD_GB[GB_LSB +: GB_W];
			st_r.guardRsv <= RST_HOLD_GB[0 +: GB_RSV_W];
			st_r.incOut <= 10'h000;
			st_r.rdata <= 8'h00;
			st_r.rvalid <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign rdata = st_r.rdata;
	assign rvalid = st_r.rvalid;
	assign phaseIncrement = st_r.incOut;
	// The guardband goes only to the flag comparator; nothing here reaches the
	// capture path, which keeps the setting purely informational.
	assign holdGuardCode = st_r.guard; // [RULE_06]
	assign holdGuardPs = GB_PS_W'(GB_STEP_PS * int'(st_r.guard)); // [RULE_05]

	////////////////////////////////////////////////////////////////////////////////
	// Each check on a read or write request samples one edge after the last request of its sequence, when the registered result
	// stands; a read in the same cycle as a write sees the older value.
	a_low_write: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_01]
		req.wr && req.addr == OFS_INC_LOW |=> st_r.incLow == $past(req.wdata))
		else $error("low increment not stored");

	a_low_read: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_01]
		req.rd && req.addr == OFS_INC_LOW |=> rdata == $past(st_r.incLow))
		else $error("low increment readback wrong");

	a_low_keep: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_01]
		!(req.wr && req.addr == OFS_INC_LOW) |=> $stable(st_r.incLow))
		else $error("low increment changed without write");

	a_high_write: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_02]
		req.wr && req.addr == OFS_INC_HIGH ##1 req.rd && req.addr == OFS_INC_HIGH |=>
		rdata == {6'h00, $past(req.wdata[1:0], 2)})
		else $error("high increment readback wrong");

	a_high_unused: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_02]
		req.rd && req.addr == OFS_INC_HIGH |=> rdata[7:2] == 6'h00)
		else $error("unused high increment bits not zero");

	a_high_keep: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_02]
		!(req.wr && req.addr == OFS_INC_HIGH) |=> $stable(st_r.incHigh))
		else $error("high increment changed without write");

	a_inc_concat: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_03]
		xferStrobe && !req.wr |=> phaseIncrement == {st_r.incHigh, st_r.incLow})
		else $error("increment word not concatenated");

	a_guard_write: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_04]
		req.wr && req.addr == OFS_HOLD_GB |=> holdGuardCode == $past(req.wdata[7:5]))
		else $error("guardband code not stored");

	a_guard_read: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_04]
		req.rd && req.addr == OFS_HOLD_GB |=>
		rdata == {$past(holdGuardCode), $past(st_r.guardRsv)})
		else $error("guardband readback wrong");

	a_guard_keep: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_04]
		!(req.wr && req.addr == OFS_HOLD_GB) |=> $stable(holdGuardCode))
		else $error("guardband code changed without write");

	a_guard_ps: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_05]
		holdGuardCode == 3'h7 |-> holdGuardPs == 8'hf5)
		else $error("guardband full scale wrong");

	a_guard_scale: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_05]
		holdGuardPs == GB_PS_W'(35 * int'(holdGuardCode)))
		else $error("guardband step wrong");

	a_guard_none: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_05]
		holdGuardCode == 3'h0 |-> holdGuardPs == 8'h00)
		else $error("guardband zero code not zero");

	a_guard_isolated: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_06]
		!xferStrobe |=> $stable(phaseIncrement))
		else $error("increment moved without strobe");

	a_guard_apart: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_06]
		req.wr && req.addr == OFS_HOLD_GB |=> $stable(st_r.incLow) && $stable(st_r.incHigh))
		else $error("guardband write touched increment");

	a_reset_zero: assert property (@(posedge mclk) // [RULE_07]
		$rose(nrst) |-> phaseIncrement == 10'h000 && holdGuardCode == 3'h0)
		else $error("reset values not zero");

	a_reset_regs: assert property (@(posedge mclk) // [RULE_07]
		$rose(nrst) |-> {st_r.guard, st_r.guardRsv} == RST_HOLD_GB && st_r.incLow == RST_INC_LOW)
		else $error("register reset values wrong");

	a_no_mix: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_08]
		!xferStrobe ##1 !xferStrobe |-> $stable(phaseIncrement))
		else $error("half increment reached oscillator");

	a_strobe_pair: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_08]
		xferStrobe && req.wr && req.addr == OFS_INC_LOW |=>
		phaseIncrement == {$past(st_r.incHigh), $past(req.wdata)})
		else $error("same cycle low write missed by strobe");

	a_high_capture: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_08]
		xferStrobe && req.wr && req.addr == OFS_INC_HIGH |=>
		phaseIncrement == {$past(req.wdata[1:0]), $past(st_r.incLow)})
		else $error("same cycle high write missed by strobe");

	a_hold_out: assert property (@(posedge mclk) disable iff (!nrst) // [RULE_08]
		!xferStrobe && req.wr && (req.addr == OFS_INC_LOW || req.addr == OFS_INC_HIGH) |=>
		$stable(phaseIncrement))
		else $error("increment write reached oscillator early");

	a_unmapped_read: assert property (@(posedge mclk) disable iff (!nrst)
		req.rd && req.addr != OFS_INC_LOW && req.addr != OFS_INC_HIGH &&
		req.addr != OFS_HOLD_GB |=> rdata == 8'h00)
		else $error("unmapped read not zero");

	a_read_pulse: assert property (@(posedge mclk) disable iff (!nrst)
		req.rd |=> rvalid)
		else $error("read not answered");

	a_idle_quiet: assert property (@(posedge mclk) disable iff (!nrst)
		!req.rd |=> !rvalid && rdata == 8'h00)
		else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ### testbench/nco_tuning_and_hold_guard_regs_test.sv
// Self-checking bench for the oscillator tuning and hold guardband registers.
`timescale 1ns/1ps
`default_nettype none
module nco_tuning_and_hold_guard_regs_test import nco_guard_pkg::*;;
logic mclk = 1'b0;
logic nrst = 1'b0;
logic xferStrobe = 1'b0;
reg_req_t req = '0;
logic [DATA_W-1:0] rdata;
logic rvalid;
logic [INC_W-1:0] phaseIncrement;
logic [GB_W-1:0] holdGuardCode;
logic [GB_PS_W-1:0] holdGuardPs;
int n_errors = 0;
int samples_checked = 0;
always #2 mclk = ~mclk;
nco_tuning_and_hold_guard_regs u_dut (.mclk(mclk), .nrst(nrst), .req(req),
	.xferStrobe(xferStrobe), .rdata(rdata), .rvalid(rvalid), .phaseIncrement(phaseIncrement),
	.holdGuardCode(holdGuardCode), .holdGuardPs(holdGuardPs));
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
	samples_checked++;
	if (got !== exp) begin
		n_errors++;
		$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
	@(negedge mclk);
	req.wr = 1'b1;
	req.addr = a;
	req.wdata = d;
	@(negedge mclk);
	req.wr = 1'b0;
endtask
// Read data is looked at only in the single cycle that rvalid stands.
task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
	@(negedge mclk);
	req.rd = 1'b1;
	req.addr = a;
	@(negedge mclk);
	req.rd = 1'b0;
	chk(16'(rvalid), 16'h1);
	chk(16'(rdata), 16'(exp));
endtask
task automatic t_reset;
	rdc(OFS_INC_LOW, RST_INC_LOW);
	rdc(OFS_INC_HIGH, RST_INC_HIGH);
	rdc(OFS_HOLD_GB, RST_HOLD_GB);
	chk(16'(phaseIncrement), 16'h0);
	chk(16'(holdGuardPs), 16'h0);
endtask
task automatic t_inc;
	wr(OFS_INC_LOW, 8'ha5);
	wr(OFS_INC_HIGH, 8'hfe);
	rdc(OFS_INC_LOW, 8'ha5);
	rdc(OFS_INC_HIGH, 8'h02);
	chk(16'(phaseIncrement), 16'h0);
	@(negedge mclk);
	xferStrobe = 1'b1;
	@(negedge mclk);
	xferStrobe = 1'b0;
	chk(16'(phaseIncrement), 16'h2a5);
	rdc(10'h13c, 8'h00);
endtask
task automatic t_guard;
	for (int c = 0; c < 8; c++) begin
		wr(OFS_HOLD_GB, {c[2:0], 5'h15});
		chk(16'(holdGuardCode), 16'(c));
		chk(16'(holdGuardPs), 16'(c * GB_STEP_PS));
		rdc(OFS_HOLD_GB, {c[2:0], 5'h15});
		chk(16'(phaseIncrement), 16'h2a5);
	end
endtask
// Write then read back to back, then strobe together with a write to each half.
task automatic t_pair;
	@(negedge mclk);
	req.wr = 1'b1;
	req.addr = OFS_INC_HIGH;
	req.wdata = 8'h01;
	@(negedge mclk);
	req.wr = 1'b0;
	req.rd = 1'b1;
	@(negedge mclk);
	req.rd = 1'b0;
	chk(16'(rvalid), 16'h1);
	chk(16'(rdata), 16'h01);
	req.wr = 1'b1;
	req.addr = OFS_INC_LOW;
	req.wdata = 8'h3c;
	xferStrobe = 1'b1;
	@(negedge mclk);
	chk(16'(phaseIncrement), 16'h13c);
	req.addr = OFS_INC_HIGH;
	req.wdata = 8'h02;
	@(negedge mclk);
	req.wr = 1'b0;
	xferStrobe = 1'b0;
	chk(16'(phaseIncrement), 16'h23c);
endtask
task automatic t_stray;
	wr(10'h13c, 8'hff);
	rdc(10'h13c, 8'h00);
	rdc(OFS_INC_LOW, 8'h3c);
	rdc(OFS_INC_HIGH, 8'h02);
	rdc(OFS_HOLD_GB, 8'hf5);
endtask
// A reset in mid-run must clear values that differ from the reset state.
task automatic t_rereset;
	@(negedge mclk);
	nrst = 1'b0;
	repeat (2) @(negedge mclk);
	nrst = 1'b1;
	t_reset();
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic wrap_up;
	if (n_errors == 0 && samples_checked > 0) begin
		$display("Testbench passed");
	end else begin
		$display("Testbench failed");
	end
	$finish;
endtask
initial begin
	repeat (2) @(negedge mclk);
	nrst = 1'b1;
	t_reset();
	t_inc();
	t_guard();
	t_pair();
	t_stray();
	t_rereset();
	wrap_up();
end
// The tests need about 75 cycles, so 500 cycles means a hang.
initial begin
	#2000;
	n_errors++;
	wrap_up();
end
endmodule
`default_nettype wire
